// file: verilog/gbl_pkg.sv
// Constants for the output boolean logic and special input block.
// Assumes a 20 MHz system clock and a plain strobe register port.
package gbl_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_IN = 8;
   localparam int NUM_OUT = 16;
   localparam int NUM_RAIL = 16;
   localparam int NUM_FLT = 9;
   localparam int NUM_SRC_OUT = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int DLY_W = 8;
   localparam int TO_W = 16;
   localparam int TYPE_W = 5;
   localparam int CFG_W = 16;
   localparam int SEL_W = 21;
   localparam int CNT_W = 24;
   localparam int PRESC_W = 15;
   // ==========================================================
   // Timing: delays and timeouts are counted in milliseconds
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
   // ==========================================================
   // Register map (byte addresses on the plain port)
   localparam logic [ADDR_W-1:0] REG_CFG_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] REG_T0_SEL_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] REG_T0_RAIL_BASE = 8'h20;
   localparam logic [ADDR_W-1:0] REG_T1_SEL_BASE = 8'h30;
   localparam logic [ADDR_W-1:0] REG_T1_RAIL_BASE = 8'h40;
   localparam logic [ADDR_W-1:0] REG_IN_POL = 8'h50;
   localparam logic [ADDR_W-1:0] REG_SPECIAL = 8'h51;
   localparam logic [ADDR_W-1:0] REG_MARGIN_MASK = 8'h52;
   localparam logic [ADDR_W-1:0] REG_SEQUENCING_TIMEOUT_VALUE = 8'h53;
   localparam logic [ADDR_W-1:0] REG_PIN_STATE = 8'h54;
   localparam logic [ADDR_W-1:0] REG_SEQ_FAULT = 8'h55;
   localparam logic [ADDR_W-1:0] REG_LATCH_CLEAR = 8'h56;
   localparam logic [ADDR_W-1:0] REG_IN_STATE = 8'h57;
   // ==========================================================
   // Output configuration fields (output_logic_config_command)
   localparam int CFG_LOGIC = 0;
   localparam int CFG_DIRECT = 1;
   localparam int CFG_ACT_HIGH = 2;
   localparam int CFG_OPEN_DRAIN = 3;
   localparam int CFG_SM = 4;
   localparam int CFG_DLY_ASSERT = 5;
   localparam int CFG_DLY_DEASSERT = 6;
   localparam int CFG_IGNORE = 7;
   localparam int CFG_DLY_LSB = 8;
   localparam logic [CFG_W-1:0] CFG_RST = 16'h0004;
   // AND-term select fields
   localparam int SEL_IN_LSB = 0;
   localparam int SEL_OUT_LSB = 8;
   localparam int SEL_TYPE_LSB = 16;
   // Special input function slots, 4 bits each: enable and pin index
   localparam int SPF_W = 4;
   localparam int SPF_EN = 3;
   localparam int SPF_SEQ = 0;
   localparam int SPF_CLR = 1;
   localparam int SPF_MEN = 2;
   localparam int SPF_MLOW = 3;
   // ==========================================================
   // Rail status types selectable per AND term
   localparam logic [TYPE_W-1:0] ST_PG = 5'h00;
   localparam logic [TYPE_W-1:0] ST_MEN = 5'h01;
   localparam logic [TYPE_W-1:0] ST_MLOW = 5'h02;
   localparam int ST_FLT_BASE = 3;
   localparam int ST_LATCH_BASE = 12;
   // Fault and warning order inside the raw and latched sets
   localparam int F_OV_FAULT = 0;
   localparam int F_OV_WARN = 1;
   localparam int F_UV_WARN = 2;
   localparam int F_UV_FAULT = 3;
   localparam int F_TON_MAX = 4;
   localparam int F_TOFF_MAX = 5;
   localparam int F_SEQ_ON = 6;
   localparam int F_SEQ_OFF = 7;
   localparam int F_WATCHDOG = 8;
endpackage

// file: verilog/gbl_out_delay.sv
// Assertion/deassertion delay filter for one logic-driven output.
// Assumes result_i is a same-clock signal; counts in system clocks.
`timescale 1ns/1ps
module gbl_out_delay #(
   parameter int TICK_CYCLES = gbl_pkg::TICK_CYCLES_DEF
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic result_i,
   input wire logic [gbl_pkg::DLY_W-1:0] delay_i,
   input wire logic dly_assert_i,
   input wire logic dly_deassert_i,
   input wire logic ignore_i,
   output logic state_o,
   output logic busy_o
);
   import gbl_pkg::*;

   typedef struct packed {
      logic state;
      logic pend;
      logic target;
      logic [CNT_W-1:0] cnt;
   } gbl_dly_t;

   gbl_dly_t st;
   gbl_dly_t next_st;
   logic dir_delayed;
   logic [CNT_W-1:0] dly_len;

   // ==========================================================
   // Next state
   always_comb begin
      next_st = st;
      dir_delayed = result_i ? dly_assert_i : dly_deassert_i;
      dly_len = CNT_W'(delay_i) * CNT_W'(TICK_CYCLES);
      if (st.pend) begin
         if (!ignore_i && (result_i != st.target)) begin
            next_st.pend = 1'b0;
         end else if (st.cnt <= CNT_W'(1)) begin
            next_st.state = st.target;
            next_st.pend = 1'b0;
         end else begin
            next_st.cnt = st.cnt - CNT_W'(1);
         end
      end else if (result_i != st.state) begin
         if (dir_delayed && (delay_i != '0)) begin
            next_st.pend = 1'b1;
            next_st.target = result_i;
            next_st.cnt = dly_len;
         end else begin
            next_st.state = result_i;
         end
      end
   end

   // ==========================================================
   // State register, frozen while the clock enable is low
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign state_o = st.state;
   assign busy_o = st.pend;
endmodule

// file: verilog/gbl_logic_out.sv
// Boolean output logic, output delays and special input functions.
// Assumes rail status flags come from same-clock sequencer logic and
// input pins are asynchronous; registers sit on a plain strobe port.
//
// Behaviour
// - Logic output is OR of two ANDs
// - Terms use inputs, rail flags, first eight outputs
// - One status type per term, any rails
// - Latched flags hold until command or pin
// - Power good, margin, faults, warnings, latched variants
// - Delay on assert, deassert, both or none
// - Normal delay drops changes shorter than delay
// - Ignore option applies change after full delay
// - Ignore option: pulses at least delay wide; here only if the return change is delayed too
// - State machine: true result uses term 0
// - State machine: false result uses term 1
// - Outputs driven directly or by logic
// - One pin per special input function
// - Sequencing timeout fault after power good
// - Latch-clear input clears latched flags
// - Margin enable margins enabled rails
// - Low-select chooses margin low or high
// - Input polarity set before any use
// - First three inputs select rail state
// - Output polarity and open-drain or push-pull
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module gbl_logic_out #(
   parameter int TICK_CYCLES = gbl_pkg::TICK_CYCLES_DEF
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [gbl_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [gbl_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [gbl_pkg::DATA_W-1:0] reg_rdata_o,
   input wire logic [gbl_pkg::NUM_IN-1:0] general_input_pin_i,
   input wire logic [gbl_pkg::NUM_RAIL-1:0] power_good_i,
   input wire logic [gbl_pkg::NUM_RAIL-1:0] overvoltage_fault_flag_i,
   input wire logic [gbl_pkg::NUM_RAIL-1:0] overvoltage_warning_flag_i,
   input wire logic [gbl_pkg::NUM_RAIL-1:0] undervoltage_warning_flag_i,
   input wire logic [gbl_pkg::NUM_RAIL-1:0] undervoltage_fault_flag_i,
   input wire logic [gbl_pkg::NUM_RAIL-1:0] turn_on_too_long_fault_flag_i,
   input wire logic [gbl_pkg::NUM_RAIL-1:0] turn_off_too_long_warning_flag_i,
   input wire logic [gbl_pkg::NUM_RAIL-1:0] sequence_on_timeout_flag_i,
   input wire logic [gbl_pkg::NUM_RAIL-1:0] sequence_off_timeout_flag_i,
   input wire logic [gbl_pkg::NUM_RAIL-1:0] watchdog_timeout_flag_i,
   output logic [gbl_pkg::NUM_OUT-1:0] general_output_pin_o,
   output logic [gbl_pkg::NUM_OUT-1:0] general_output_pin_oe_o,
   output logic [gbl_pkg::NUM_RAIL-1:0] rail_margin_en_o,
   output logic margin_low_not_high_flag_o,
   output logic [2:0] rail_state_sel_o,
   output logic [gbl_pkg::NUM_RAIL-1:0] sequencing_timeout_value_fault_o
);
   import gbl_pkg::*;

   typedef struct packed {
      logic [NUM_IN-1:0] sync1;
      logic [NUM_IN-1:0] sync2;
      logic [NUM_OUT-1:0][CFG_W-1:0] cfg;
      logic [1:0][NUM_OUT-1:0][SEL_W-1:0] sel;
      logic [1:0][NUM_OUT-1:0][NUM_RAIL-1:0] rmask;
      logic [NUM_IN-1:0] pol;
      logic [4*SPF_W-1:0] special;
      logic [NUM_RAIL-1:0] mrg_mask;
      logic [TO_W-1:0] seq_to;
      logic [NUM_FLT-1:0][NUM_RAIL-1:0] latched;
      logic [NUM_RAIL-1:0] pg_prev;
      logic [NUM_RAIL-1:0] seq_run;
      logic [NUM_RAIL-1:0] seq_fault;
      logic [NUM_RAIL-1:0][TO_W-1:0] seq_cnt;
      logic [PRESC_W-1:0] presc;
      logic [DATA_W-1:0] rdata;
   } gbl_state_t;

   gbl_state_t st;
   gbl_state_t next_st;
   logic [NUM_IN-1:0] in_act;
   logic src_seq, src_clr, src_men, src_mlow;
   logic tick;
   logic latch_clr;
   logic [NUM_RAIL-1:0] men_vec;
   logic [NUM_FLT-1:0][NUM_RAIL-1:0] raw;
   logic [31:0][NUM_RAIL-1:0] stat;
   logic [1:0][NUM_OUT-1:0] term;
   logic [NUM_OUT-1:0] result;
   logic [NUM_OUT-1:0] filt;
   logic [NUM_OUT-1:0] pend;
   logic [NUM_OUT-1:0] logical;
   logic [NUM_OUT-1:0] level;
   logic [3:0] idx;

   // ==========================================================
   // Helpers
   // A special function is live only when assigned; one pin index per
   // slot means no function can ever have two sources.
   function automatic logic spf_active(input logic [SPF_W-1:0] f, input logic [NUM_IN-1:0] act);
      spf_active = f[SPF_EN] & act[f[2:0]];
   endfunction

   // An AND term with nothing selected stays false
   function automatic logic term_hit(input logic [SEL_W-1:0] s, input logic [NUM_RAIL-1:0] m,
                                     input logic [NUM_IN-1:0] ins, input logic [NUM_SRC_OUT-1:0] outs,
                                     input logic [NUM_RAIL-1:0] flags);
      logic [NUM_IN-1:0] si;
      logic [NUM_SRC_OUT-1:0] so;
      si = s[SEL_IN_LSB +: NUM_IN];
      so = s[SEL_OUT_LSB +: NUM_SRC_OUT];
      term_hit = (|si | |so | |m) & (&(ins | ~si)) & (&(outs | ~so)) & (&(flags | ~m));
   endfunction

   // ==========================================================
   // Input polarity and special functions, after the synchroniser
   assign in_act = st.sync2 ^ ~st.pol;
   assign src_seq = spf_active(st.special[SPF_SEQ*SPF_W +: SPF_W], in_act);
   assign src_clr = spf_active(st.special[SPF_CLR*SPF_W +: SPF_W], in_act);
   assign src_men = spf_active(st.special[SPF_MEN*SPF_W +: SPF_W], in_act);
   assign src_mlow = spf_active(st.special[SPF_MLOW*SPF_W +: SPF_W], in_act);
   assign men_vec = st.mrg_mask & {NUM_RAIL{src_men}};
   assign rail_margin_en_o = men_vec;
   assign margin_low_not_high_flag_o = src_men & src_mlow;
   assign rail_state_sel_o = in_act[2:0];
   assign sequencing_timeout_value_fault_o = st.seq_fault;
   assign tick = (st.presc == PRESC_W'(TICK_CYCLES - 1));
   assign idx = reg_addr_i[3:0];
   // Bus clear and pin clear share one path
   assign latch_clr = src_clr | (reg_wr_i && (reg_addr_i == REG_LATCH_CLEAR));

   // ==========================================================
   // Raw flags and the status type matrix feeding the terms
   always_comb begin
      raw[F_OV_FAULT] = overvoltage_fault_flag_i;
      raw[F_OV_WARN] = overvoltage_warning_flag_i;
      raw[F_UV_WARN] = undervoltage_warning_flag_i;
      raw[F_UV_FAULT] = undervoltage_fault_flag_i;
      raw[F_TON_MAX] = turn_on_too_long_fault_flag_i;
      raw[F_TOFF_MAX] = turn_off_too_long_warning_flag_i;
      raw[F_SEQ_ON] = sequence_on_timeout_flag_i | st.seq_fault;
      raw[F_SEQ_OFF] = sequence_off_timeout_flag_i;
      raw[F_WATCHDOG] = watchdog_timeout_flag_i;
      stat = '0;
      stat[ST_PG] = power_good_i;
      stat[ST_MEN] = men_vec;
      stat[ST_MLOW] = men_vec & {NUM_RAIL{src_mlow}};
      for (int k = 0; k < NUM_FLT; k++) begin
         stat[ST_FLT_BASE + k] = raw[k];
         stat[ST_LATCH_BASE + k] = st.latched[k];
      end
   end

   // ==========================================================
   // Per-output logic, delay filter and pin drive
   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
         logic [CFG_W-1:0] c;
         assign c = st.cfg[gi];
         assign term[0][gi] = term_hit(st.sel[0][gi], st.rmask[0][gi], in_act, logical[NUM_SRC_OUT-1:0],
                                       stat[st.sel[0][gi][SEL_TYPE_LSB +: TYPE_W]]);
         assign term[1][gi] = term_hit(st.sel[1][gi], st.rmask[1][gi], in_act, logical[NUM_SRC_OUT-1:0],
                                       stat[st.sel[1][gi][SEL_TYPE_LSB +: TYPE_W]]);
         // State machine mode trades the OR for a two-state hysteresis
         assign result[gi] = c[CFG_SM] ? (filt[gi] ? term[0][gi] : term[1][gi])
                                       : (term[0][gi] | term[1][gi]);
         gbl_out_delay #(
            .TICK_CYCLES(TICK_CYCLES)
         ) u_dly (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .ce_i(ce_i),
            .result_i(result[gi]),
            .delay_i(c[CFG_DLY_LSB +: DLY_W]),
            .dly_assert_i(c[CFG_DLY_ASSERT]),
            .dly_deassert_i(c[CFG_DLY_DEASSERT]),
            .ignore_i(c[CFG_IGNORE]),
            .state_o(filt[gi]),
            .busy_o(pend[gi])
         );
         assign logical[gi] = c[CFG_LOGIC] ? filt[gi] : c[CFG_DIRECT];
         assign level[gi] = logical[gi] ^ ~c[CFG_ACT_HIGH];
         // Open drain only pulls low; the pin is released for a high level
         assign general_output_pin_o[gi] = c[CFG_OPEN_DRAIN] ? 1'b0 : level[gi];
         assign general_output_pin_oe_o[gi] = c[CFG_OPEN_DRAIN] ? ~level[gi] : 1'b1;
      end
   endgenerate

   // ==========================================================
   // Next state: synchroniser, registers, latches, timeouts, reads
   always_comb begin
      next_st = st;
      next_st.sync1 = general_input_pin_i;
      next_st.sync2 = st.sync1;
      next_st.presc = tick ? '0 : st.presc + PRESC_W'(1);
      // Register writes
      if (reg_wr_i) begin
         if (reg_addr_i[7:4] == REG_CFG_BASE[7:4]) begin
            next_st.cfg[idx] = reg_wdata_i[CFG_W-1:0];
         end else if (reg_addr_i[7:4] == REG_T0_SEL_BASE[7:4]) begin
            next_st.sel[0][idx] = reg_wdata_i[SEL_W-1:0];
         end else if (reg_addr_i[7:4] == REG_T0_RAIL_BASE[7:4]) begin
            next_st.rmask[0][idx] = reg_wdata_i[NUM_RAIL-1:0];
         end else if (reg_addr_i[7:4] == REG_T1_SEL_BASE[7:4]) begin
            next_st.sel[1][idx] = reg_wdata_i[SEL_W-1:0];
         end else if (reg_addr_i[7:4] == REG_T1_RAIL_BASE[7:4]) begin
            next_st.rmask[1][idx] = reg_wdata_i[NUM_RAIL-1:0];
         end else if (reg_addr_i == REG_IN_POL) begin
            next_st.pol = reg_wdata_i[NUM_IN-1:0];
         end else if (reg_addr_i == REG_SPECIAL) begin
            next_st.special = reg_wdata_i[4*SPF_W-1:0];
         end else if (reg_addr_i == REG_MARGIN_MASK) begin
            next_st.mrg_mask = reg_wdata_i[NUM_RAIL-1:0];
         end else if (reg_addr_i == REG_SEQUENCING_TIMEOUT_VALUE) begin
            next_st.seq_to = reg_wdata_i[TO_W-1:0];
         end
      end
      // Latched flags: a new event beats a clear in the same cycle
      for (int k = 0; k < NUM_FLT; k++) begin
         next_st.latched[k] = raw[k] | (st.latched[k] & ~{NUM_RAIL{latch_clr}});
      end
      // Sequencing timeout watch, one per rail, counted in ms ticks
      for (int r = 0; r < NUM_RAIL; r++) begin
         logic set_f;
         set_f = 1'b0;
         next_st.pg_prev[r] = power_good_i[r];
         if (st.seq_run[r]) begin
            if (src_seq) begin
               next_st.seq_run[r] = 1'b0;
            end else if (tick) begin
               if (st.seq_cnt[r] + TO_W'(1) >= st.seq_to) begin
                  set_f = 1'b1;
                  next_st.seq_run[r] = 1'b0;
               end else begin
                  next_st.seq_cnt[r] = st.seq_cnt[r] + TO_W'(1);
               end
            end
         end else if (power_good_i[r] && !st.pg_prev[r] && (st.seq_to != '0)
                      && st.special[SPF_SEQ*SPF_W + SPF_EN] && !src_seq) begin
            next_st.seq_run[r] = 1'b1;
            next_st.seq_cnt[r] = '0;
         end
         next_st.seq_fault[r] = set_f | (st.seq_fault[r] & ~latch_clr);
      end
      // Read data, valid only in the cycle after the strobe
      next_st.rdata = '0;
      if (reg_rd_i) begin
         if (reg_addr_i[7:4] == REG_CFG_BASE[7:4]) begin
            next_st.rdata = {{(DATA_W-CFG_W){1'b0}}, st.cfg[idx]};
         end else if (reg_addr_i[7:4] == REG_T0_SEL_BASE[7:4]) begin
            next_st.rdata = {{(DATA_W-SEL_W){1'b0}}, st.sel[0][idx]};
         end else if (reg_addr_i[7:4] == REG_T0_RAIL_BASE[7:4]) begin
            next_st.rdata = {{(DATA_W-NUM_RAIL){1'b0}}, st.rmask[0][idx]};
         end else if (reg_addr_i[7:4] == REG_T1_SEL_BASE[7:4]) begin
            next_st.rdata = {{(DATA_W-SEL_W){1'b0}}, st.sel[1][idx]};
         end else if (reg_addr_i[7:4] == REG_T1_RAIL_BASE[7:4]) begin
            next_st.rdata = {{(DATA_W-NUM_RAIL){1'b0}}, st.rmask[1][idx]};
         end else if (reg_addr_i == REG_IN_POL) begin
            next_st.rdata = {{(DATA_W-NUM_IN){1'b0}}, st.pol};
         end else if (reg_addr_i == REG_SPECIAL) begin
            next_st.rdata = {{(DATA_W-4*SPF_W){1'b0}}, st.special};
         end else if (reg_addr_i == REG_MARGIN_MASK) begin
            next_st.rdata = {{(DATA_W-NUM_RAIL){1'b0}}, st.mrg_mask};
         end else if (reg_addr_i == REG_SEQUENCING_TIMEOUT_VALUE) begin
            next_st.rdata = {{(DATA_W-TO_W){1'b0}}, st.seq_to};
         end else if (reg_addr_i == REG_PIN_STATE) begin
            next_st.rdata = {{(DATA_W-NUM_OUT){1'b0}}, logical};
         end else if (reg_addr_i == REG_SEQ_FAULT) begin
            next_st.rdata = {{(DATA_W-NUM_RAIL){1'b0}}, st.seq_fault};
         end else if (reg_addr_i == REG_IN_STATE) begin
            next_st.rdata = {{(DATA_W-NUM_IN){1'b0}}, in_act};
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
         for (int i = 0; i < NUM_OUT; i++) begin
            st.cfg[i] <= CFG_RST;
         end
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign reg_rdata_o = st.rdata;

   // ==========================================================
   // Assertions on outputs 0 and 1 and shared logic
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   logic [CFG_W-1:0] c0;
   logic [CFG_W-1:0] c1;
   assign c0 = st.cfg[0];
   // Output 1 carries the logic, delay and state machine checks
   assign c1 = st.cfg[1];

   property p_follow_no_delay;
      ce_i && $past(ce_i) && !$past(pend[1]) && c1[CFG_LOGIC] && !c1[CFG_SM] && !c1[CFG_DLY_ASSERT]
         && !c1[CFG_DLY_DEASSERT] && $stable(c1) |-> logical[1] == $past(term[0][1] | term[1][1]);
   endproperty
   a_follow_no_delay: assert property (p_follow_no_delay) else $error("Undelayed output lost its term OR");

   property p_glitch_filter;
      $rose(filt[1]) && $past(c1[CFG_DLY_ASSERT]) && !$past(c1[CFG_IGNORE]) && ($past(c1[CFG_DLY_LSB +: DLY_W]) != '0)
         |-> $past(result[1], 1) && $past(result[1], 2);
   endproperty
   a_glitch_filter: assert property (p_glitch_filter) else $error("Delayed assert without a held result");

   property p_state_machine_false;
      ce_i && c1[CFG_SM] && !c1[CFG_DLY_ASSERT] && !pend[1] && !filt[1] && !term[1][1] ##1 ce_i |-> !filt[1];
   endproperty
   a_state_machine_false: assert property (p_state_machine_false) else $error("False state left without term 1");

   property p_state_machine_true;
      ce_i && c1[CFG_SM] && !c1[CFG_DLY_DEASSERT] && !pend[1] && filt[1] && term[0][1] ##1 ce_i |-> filt[1];
   endproperty
   a_state_machine_true: assert property (p_state_machine_true) else $error("True state dropped while term 0 held");

   property p_latch_hold;
      ce_i && st.latched[F_OV_FAULT][0] && !latch_clr |=> st.latched[F_OV_FAULT][0];
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("Latched flag fell without a clear");

   property p_latch_clear;
      ce_i && src_clr && !overvoltage_fault_flag_i[0] |=> !st.latched[F_OV_FAULT][0];
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("Latch clear input did not clear");

   property p_margin;
      src_men && st.mrg_mask[0] |-> rail_margin_en_o[0] && (margin_low_not_high_flag_o
         == (st.special[SPF_MLOW*SPF_W + SPF_EN] && in_act[st.special[SPF_MLOW*SPF_W +: 3]]));
   endproperty
   a_margin: assert property (p_margin) else $error("Margin state does not follow the inputs");

   property p_seq_fault;
      ce_i && !st.seq_fault[0] ##1 st.seq_fault[0] |-> $past(st.seq_run[0]) && $past(tick) && !$past(src_seq);
   endproperty
   a_seq_fault: assert property (p_seq_fault) else $error("Sequencing fault without an expired watch");

   property p_open_drain;
      c0[CFG_OPEN_DRAIN] |-> !general_output_pin_o[0] && (general_output_pin_oe_o[0] == !level[0]);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("Open drain pin driven high");

   c_delayed_change: cover property ($rose(filt[1]) && c1[CFG_DLY_ASSERT]);
   c_ignore_stretch: cover property (c1[CFG_IGNORE] && $rose(filt[1]) && !result[1]);
   c_seq_fault: cover property ($rose(st.seq_fault[0]));
   c_state_machine: cover property (c1[CFG_SM] && $fell(filt[1]));
endmodule

// file: test/gbl_board_model.sv
// Board side of the output pins: pull-ups on every output net.
// Assumes the design's level and enable per pin; a released pin reads high.
`timescale 1ns/1ps
module gbl_board_model (
   input wire logic [15:0] level_i,
   input wire logic [15:0] oe_i,
   output logic [15:0] pad_o
);
   // ==========================================================
   // Pad resolution
   // Pull-up wins only when the pin is released, as on an open-drain net
   always_comb begin
      pad_o = (level_i & oe_i) | ~oe_i;
   end
endmodule

// file: test/gbl_logic_out_tb_top.sv
// Self-checking bench for the output logic and special input block.
// Assumes a 20 MHz clock and a fast millisecond tick of four clocks.
`timescale 1ns/1ps
`define CHK(a, b) begin #1; comparisons++; if ((a) !== (b)) begin err_count++; \
   $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module gbl_logic_out_tb_top;
   import gbl_pkg::*;
   logic clock_i = 0, rst_n_i = 0, wr = 0, rd = 0, ce = 1;
   logic [7:0] addr = 0, p = 0;
   logic [31:0] wd = 0, rdata, d;
   logic [15:0] pg = 0, out, oe, pad, men, stf;
   logic [15:0] fl [9] = '{default: 16'h0000};
   logic low;
   logic [2:0] sel;
   int err_count = 0, comparisons = 0, cycles = 0;
   // ==========================================================
   // Clock, design and board
   always #25 clock_i = ~clock_i;
   gbl_logic_out #(.TICK_CYCLES(4)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
      .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .general_input_pin_i(p), .power_good_i(pg), .overvoltage_fault_flag_i(fl[0]),
      .overvoltage_warning_flag_i(fl[1]), .undervoltage_warning_flag_i(fl[2]),
      .undervoltage_fault_flag_i(fl[3]), .turn_on_too_long_fault_flag_i(fl[4]),
      .turn_off_too_long_warning_flag_i(fl[5]), .sequence_on_timeout_flag_i(fl[6]),
      .sequence_off_timeout_flag_i(fl[7]), .watchdog_timeout_flag_i(fl[8]),
      .general_output_pin_o(out), .general_output_pin_oe_o(oe), .rail_margin_en_o(men),
      .margin_low_not_high_flag_o(low), .rail_state_sel_o(sel), .sequencing_timeout_value_fault_o(stf));
   gbl_board_model board (.level_i(out), .oe_i(oe), .pad_o(pad));
   // ==========================================================
   // Bus and helper tasks
   task automatic cy(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic wrr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_i);
      addr <= a; wd <= v; wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock_i);
      addr <= a; rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // One-cycle latched-fault event on rail 0, then a check that it stuck
   task automatic flt();
      fl[0][0] <= 1'b1; cy(1); fl[0][0] <= 1'b0; cy(4);
      `CHK(out[2], 1'b1)
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard: the tests need a few hundred cycles
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin err_count++; close_out(); end
   end
   // ==========================================================
   // Test sequence
   initial begin
      cy(8); rst_n_i <= 1'b1;
      wrr(8'h50, 32'h0000_00FF); `CHK(oe, 16'hFFFF)
      rdr(8'hFF, d); `CHK(d, 32'h0) $display("test reset done");
      wrr(8'h00, 32'h0006); `CHK(out[0], 1'b1)
      wrr(8'h00, 32'h000E); `CHK(pad[0], 1'b1)
      `CHK(oe[0], 1'b0)
      wrr(8'h00, 32'h000C); `CHK(pad[0], 1'b0)
      wrr(8'h00, 32'h0002); `CHK(out[0], 1'b0)
      $display("test direct done");
      wrr(8'h00, 32'h0004); wrr(8'h01, 32'h0005); wrr(8'h11, 32'h0003); wrr(8'h31, 32'h0100);
      p[0] <= 1'b1; cy(6); `CHK(out[1], 1'b0)
      p[1] <= 1'b1; cy(6); `CHK(out[1], 1'b1)
      p[0] <= 1'b0; wrr(8'h00, 32'h0006); cy(6); `CHK(out[1], 1'b1)
      $display("test logic done");
      wrr(8'h31, 32'h0); wrr(8'h00, 32'h0004); wrr(8'h01, 32'h0165); cy(12);
      p[0] <= 1'b1; cy(2); p[0] <= 1'b0; cy(12); `CHK(out[1], 1'b0)
      p[0] <= 1'b1; cy(4); `CHK(out[1], 1'b0)
      cy(8); `CHK(out[1], 1'b1)
      p[0] <= 1'b0; wrr(8'h01, 32'h01E5); cy(12); `CHK(out[1], 1'b0)
      p[0] <= 1'b1; cy(1); p[0] <= 1'b0; cy(8); `CHK(out[1], 1'b1)
      cy(2); `CHK(out[1], 1'b1)
      cy(10); `CHK(out[1], 1'b0)
      $display("test delay done");
      wrr(8'h02, 32'h0005); wrr(8'h12, 32'h000C_0000); wrr(8'h22, 32'h0001); wrr(8'h51, 32'hBAC0);
      flt(); wrr(8'h56, 32'h0); cy(2); `CHK(out[2], 1'b0)
      flt(); p[4] <= 1'b1; cy(6); `CHK(out[2], 1'b0)
      p[4] <= 1'b0; $display("test latch done");
      wrr(8'h52, 32'h0003); p[2] <= 1'b1; p[3] <= 1'b1; cy(5);
      `CHK(men, 16'h0003)
      `CHK(low, 1'b1)
      `CHK(sel, 3'b110)
      p[3] <= 1'b0; cy(5); `CHK(low, 1'b0)
      $display("test margin done");
      // State machine on output 1: term 1 sets it, term 0 holds it
      p[1] <= 1'b0; wrr(8'h01, 32'h0015); wrr(8'h11, 32'h0001); wrr(8'h31, 32'h0002);
      p[0] <= 1'b1; cy(4); `CHK(out[1], 1'b0)
      p[1] <= 1'b1; cy(4); `CHK(out[1], 1'b1)
      p[1] <= 1'b0; cy(4); `CHK(out[1], 1'b1)
      p[0] <= 1'b0; cy(4); `CHK(out[1], 1'b0)
      $display("test state machine done");
      // Sequencing watch: rail 0 times out, rail 1 is rescued by the source pin
      wrr(8'h51, 32'h0000_BACD); wrr(8'h53, 32'h0002); pg[0] <= 1'b1; cy(12);
      `CHK(stf, 16'h0001)
      rdr(8'h55, d); `CHK(d, 32'h1)
      cy(1); `CHK(rdata, 32'h0)
      wrr(8'h56, 32'h0); pg[1] <= 1'b1; p[5] <= 1'b1; cy(12);
      `CHK(stf, 16'h0000)
      $display("test sequencing done");
      // Clock enable low: a write must not land
      ce <= 1'b0; wrr(8'h00, 32'h0006); ce <= 1'b1; `CHK(out[0], 1'b0)
      wrr(8'h00, 32'h0006); `CHK(out[0], 1'b1)
      $display("test clock enable done");
      close_out();
   end
endmodule
